// ---- mii_port_consts.svh ----
// timing and coding constants for the mii port ends
`ifndef MII_PORT_CONSTS_SVH
`define MII_PORT_CONSTS_SVH
`define CLK_FREQ_KHZ      100000
`define MII_FAST_FREQ_KHZ 25000
`define MII_SLOW_FREQ_KHZ 2500
// half periods of the mii clock in system clocks
`define MII_FAST_HALF     ((`CLK_FREQ_KHZ / `MII_FAST_FREQ_KHZ) / 2)
`define MII_SLOW_HALF     ((`CLK_FREQ_KHZ / `MII_SLOW_FREQ_KHZ) / 2)
`define SYM_J             5'h18
`define SYM_K             5'h11
`define SYM_T             5'h0d
`define SYM_R             5'h07
`define SYM_HALT          5'h04
`define SYM_IDLE          5'h1f
`define PHY_ADDR_TRI      5'h00
`endif

// ---- mii_port_pkg.sv ----
// shared types for the mii port ends
package mii_port_pkg;
    typedef logic [3:0] nibble_t;
    typedef logic [4:0] symbol_t;
    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_GOTJ = 3'b010,
        RX_DATA = 3'b100
    } rx_state_e;
endpackage : mii_port_pkg

// ---- mii_link_if.sv ----
// mii signals between phy port and mac end
`timescale 1ns/1ns
`default_nettype none
interface mii_link_if;
    logic       rxclk;
    logic       rxdv;
    logic       rxer;
    logic [3:0] rxd;
    logic       rx_out_en;
    logic       receive_tristate_request;
    logic       txclk;
    logic       txen;
    logic       txer;
    logic [3:0] txd;
    modport phy (output rxclk, output rxdv, output rxer, output rxd, output rx_out_en,
                 input receive_tristate_request, output txclk, input txen, input txer, input txd);
    modport mac (input rxclk, input rxdv, input rxer, input rxd, input rx_out_en,
                 output receive_tristate_request, input txclk, output txen, output txer, output txd);
endinterface : mii_link_if
`default_nettype wire

// ---- mii_phy_port.sv ----
// phy end of the mii: receive framing, rx tri-state, tx clock and symbol encode
//
// Contract
// - rxdv rises after /J/K/ recovered
// - rxdv drops on /T/R/ or error
// - rxdv changes only with rxclk
// - rxer on errors within valid frame (code: 100 mb/s only, and rxdv drops in the same rxclk)
// - rxer on false carrier (code: 100 mb/s only)
// - rxer changes only with rxclk
// - tri-state request high disables receive drivers
// - phy address 00 acts as tri-state
// - txclk 2.5 or 25 mhz
// - txd0 is nibble lsb
// - txd sampled on rising txclk with txen
// - mac holds txen only with data
// - transmit starts when txen seen
// - transmit stops after txen drops
// - 10 mb/s ignores txer
// - 100 mb/s txer sends halt symbol
// - test bit selects alternate symbol
// - rxd lsb first, with rxclk
// - rxclk 2.5 or 25 mhz
`timescale 1ns/1ns
`default_nettype none
`include "mii_port_consts.svh"
module mii_phy_port
    import mii_port_pkg::*;
(
    input  wire logic    clk,
    input  wire logic    rstn,
    input  wire logic    clk_en,
    input  wire logic    speed_100,
    input  wire logic [4:0] phy_addr,
    input  wire logic    invalid_code_test,
    input  wire symbol_t alt_symbol,
    // received code groups from the pma, one per nibble time
    input  wire logic    rx_sym_valid,
    input  wire symbol_t rx_sym,
    output logic         rx_sym_ready,
    // encoded transmit code groups toward the pma
    output symbol_t      tx_sym_q,
    output logic         tx_sym_valid_q,
    output logic         tx_active_q,
    mii_link_if.phy      link
);

    ////////////////////////////////////////////////////////////////////////////
    // mii clock divider, shared by rx and tx
    logic [4:0] div_q;
    logic       mclk_q;
    logic [4:0] half;
    assign half = speed_100 ? 5'(`MII_FAST_HALF) : 5'(`MII_SLOW_HALF);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_q  <= 5'h00;
            mclk_q <= 1'b0;
        end else if (clk_en) begin
            if (div_q >= half - 5'h01) begin
                div_q  <= 5'h00;
                mclk_q <= ~mclk_q;
            end else begin
                div_q <= div_q + 5'h01;
            end
        end
    end
    logic mclk_rise;
    logic mclk_fall;
    assign mclk_rise = clk_en && !mclk_q && (div_q >= half - 5'h01);
    assign mclk_fall = clk_en && mclk_q && (div_q >= half - 5'h01);
    assign link.txclk = mclk_q;
    assign link.rxclk = mclk_q;

    ////////////////////////////////////////////////////////////////////////////
    // tri-state request crossing from the mac, two flops before use
    logic tri_s1_q;
    logic tri_s2_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tri_s1_q <= 1'b1;
            tri_s2_q <= 1'b1;
        end else if (clk_en) begin
            tri_s1_q <= link.receive_tristate_request;
            tri_s2_q <= tri_s1_q;
        end
    end
    // released rx pins keep only one phy on a shared bus
    assign link.rx_out_en = !(tri_s2_q || phy_addr == `PHY_ADDR_TRI);

    ////////////////////////////////////////////////////////////////////////////
    // two-entry skid buffer between pma symbols and the rx framer
    symbol_t    buf_q [2];
    logic [1:0] cnt_q;
    logic       rd_ptr_q;
    logic       wr_ptr_q;
    logic       pop;
    logic       push;
    assign rx_sym_ready = (cnt_q != 2'h2);
    assign push = clk_en && rx_sym_valid && rx_sym_ready;
    assign pop  = mclk_fall && (cnt_q != 2'h0);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q    <= 2'h0;
            rd_ptr_q <= 1'b0;
            wr_ptr_q <= 1'b0;
        end else begin
            if (push) wr_ptr_q <= ~wr_ptr_q;
            if (pop) rd_ptr_q <= ~rd_ptr_q;
            cnt_q <= cnt_q + 2'(push) - 2'(pop);
        end
    end
    always_ff @(posedge clk) begin
        if (push) buf_q[wr_ptr_q] <= rx_sym;
    end

    ////////////////////////////////////////////////////////////////////////////
    // 4b/5b data decode; invalid codes flag an error
    function automatic logic [4:0] decode(input symbol_t s);
        logic [4:0] r;
        r = 5'h10;
        unique case (s)
            5'h1e: r = 5'h00; 5'h09: r = 5'h01; 5'h14: r = 5'h02; 5'h15: r = 5'h03;
            5'h0a: r = 5'h04; 5'h0b: r = 5'h05; 5'h0e: r = 5'h06; 5'h0f: r = 5'h07;
            5'h12: r = 5'h08; 5'h13: r = 5'h09; 5'h16: r = 5'h0a; 5'h17: r = 5'h0b;
            5'h1a: r = 5'h0c; 5'h1b: r = 5'h0d; 5'h1c: r = 5'h0e; 5'h1d: r = 5'h0f;
            default: r = 5'h10;
        endcase
        return r;
    endfunction : decode

    ////////////////////////////////////////////////////////////////////////////
    // rx framer: all rx outputs update on the falling mii edge, stable at rise
    rx_state_e  rx_q;
    logic       rxdv_q;
    logic       rxer_q;
    nibble_t    rxd_q;
    logic       prev_t_q;
    symbol_t    cur;
    logic [4:0] dec;
    assign cur = buf_q[rd_ptr_q];
    assign dec = decode(cur);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_q     <= RX_IDLE;
            rxdv_q   <= 1'b0;
            rxer_q   <= 1'b0;
            rxd_q    <= 4'h0;
            prev_t_q <= 1'b0;
        end else if (pop) begin
            rxer_q   <= 1'b0;
            prev_t_q <= 1'b0;
            unique case (rx_q)
                RX_IDLE: begin
                    rxdv_q <= 1'b0;
                    if (cur == `SYM_J) begin
                        rx_q <= RX_GOTJ;
                    end else if (speed_100 && cur != `SYM_IDLE) begin
                        rxer_q <= 1'b1; // false carrier
                        rxd_q  <= 4'he;
                    end
                end
                RX_GOTJ: begin
                    if (cur == `SYM_K) begin
                        rx_q   <= RX_DATA;
                        rxdv_q <= 1'b1;
                        rxd_q  <= 4'h5;
                    end else begin
                        rx_q   <= RX_IDLE;
                        rxer_q <= speed_100;
                        rxd_q  <= 4'he; // lost delimiter reads as false carrier
                    end
                end
                RX_DATA: begin
                    if (cur == `SYM_T) begin
                        prev_t_q <= 1'b1;
                    end else if (prev_t_q && cur == `SYM_R) begin
                        rx_q   <= RX_IDLE;
                        rxdv_q <= 1'b0;
                    end else if (dec[4]) begin
                        rx_q   <= RX_IDLE;
                        rxdv_q <= 1'b0;
                        rxer_q <= speed_100;
                    end else begin
                        rxd_q <= dec[3:0];
                    end
                end
                default: rx_q <= RX_IDLE;
            endcase
        end
    end
    assign link.rxdv = rxdv_q;
    assign link.rxer = rxer_q;
    assign link.rxd  = rxd_q; // bit 0 is lsb

    ////////////////////////////////////////////////////////////////////////////
    // tx pin synchronisers
    logic [5:0] tx_s1_q;
    logic [5:0] tx_s2_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_s1_q <= 6'h00;
            tx_s2_q <= 6'h00;
        end else if (clk_en) begin
            tx_s1_q <= {link.txer, link.txen, link.txd};
            tx_s2_q <= tx_s1_q;
        end
    end

    // 4b/5b data encode
    function automatic symbol_t encode(input nibble_t n);
        symbol_t t [16];
        t = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
              5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
        return t[n];
    endfunction : encode

    ////////////////////////////////////////////////////////////////////////////
    // tx sampling; two-flop sync delay equals the 25 mhz mii half period, short only against the 2.5 mhz one
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_sym_q       <= `SYM_IDLE;
            tx_sym_valid_q <= 1'b0;
            tx_active_q    <= 1'b0;
        end else if (clk_en) begin
            tx_sym_valid_q <= 1'b0;
            if (mclk_rise) begin
                tx_active_q    <= tx_s2_q[4];
                tx_sym_valid_q <= tx_s2_q[4];
                if (!tx_s2_q[4]) begin
                    tx_sym_q <= `SYM_IDLE;
                end else if (speed_100 && tx_s2_q[5]) begin
                    tx_sym_q <= invalid_code_test ? alt_symbol : `SYM_HALT;
                end else begin
                    tx_sym_q <= encode(tx_s2_q[3:0]);
                end
            end
        end
    end
endmodule : mii_phy_port
`default_nettype wire

// ---- mii_mac_end.sv ----
// mac end of the mii: drives transmit nibbles, collects receive nibbles
`timescale 1ns/1ns
`default_nettype none
`include "mii_port_consts.svh"
module mii_mac_end
    import mii_port_pkg::*;
(
    input  wire logic    clk,
    input  wire logic    rstn,
    input  wire logic    clk_en,
    input  wire logic    rx_tristate,
    input  wire logic    tx_valid,
    input  wire nibble_t tx_nibble,
    input  wire logic    tx_err,
    output logic         tx_ready,
    output logic         rx_valid_q,
    output nibble_t      rx_nibble_q,
    output logic         rx_err_q,
    output logic         rx_frame_q,
    mii_link_if.mac      link
);
    // synchronise the phy clocks and receive pins
    logic [7:0] s1_q;
    logic [7:0] s2_q;
    logic       tck_q;
    logic       rck_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_q  <= 8'h00;
            s2_q  <= 8'h00;
            tck_q <= 1'b0;
            rck_q <= 1'b0;
        end else if (clk_en) begin
            s1_q  <= {link.txclk, link.rxclk, link.rxer, link.rxdv, link.rxd};
            s2_q  <= s1_q;
            tck_q <= s2_q[7];
            rck_q <= s2_q[6];
        end
    end
    logic tck_fall;
    logic rck_rise;
    assign tck_fall = clk_en && tck_q && !s2_q[7];
    assign rck_rise = clk_en && !rck_q && s2_q[6];

    ////////////////////////////////////////////////////////////////////////////
    // tristate request level and transmit launch after falling txclk
    logic    txen_q;
    logic    txer_q;
    nibble_t txd_q;
    assign tx_ready = tck_fall;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txen_q <= 1'b0;
            txer_q <= 1'b0;
            txd_q  <= 4'h0;
        end else if (tck_fall) begin // stable by next rise
            txen_q <= tx_valid;
            txer_q <= tx_valid && tx_err;
            txd_q  <= tx_nibble;
        end
    end
    assign link.txen = txen_q;
    assign link.txer = txer_q;
    assign link.txd  = txd_q;
    assign link.receive_tristate_request = rx_tristate;

    // receive capture on rising rxclk, whether or not rx_out_en shows the phy driving the pins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_valid_q  <= 1'b0;
            rx_nibble_q <= 4'h0;
            rx_err_q    <= 1'b0;
            rx_frame_q  <= 1'b0;
        end else if (clk_en) begin
            rx_valid_q <= 1'b0;
            if (rck_rise) begin
                rx_frame_q  <= s2_q[4];
                rx_valid_q  <= s2_q[4];
                rx_nibble_q <= s2_q[3:0];
                rx_err_q    <= s2_q[5];
            end
        end
    end
endmodule : mii_mac_end
`default_nettype wire

// ---- mii_link_properties.sv ----
// link assertions between the phy port and the mac end
`timescale 1ns/1ns
`default_nettype none
module mii_link_properties (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       rxclk,
    input wire logic       rxdv,
    input wire logic       rxer,
    input wire logic [3:0] rxd,
    input wire logic       rx_out_en,
    input wire logic       receive_tristate_request,
    input wire logic       txclk
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////////
    // cycles the link clock stood at a level; first half skipped, it may be partial
    logic       txclk_q;
    logic       seen_q;
    logic [5:0] half_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txclk_q <= 1'b0;
            seen_q  <= 1'b0;
            half_q  <= 6'h00;
        end else begin
            txclk_q <= txclk;
            seen_q  <= seen_q | (txclk ^ txclk_q);
            half_q  <= (txclk ^ txclk_q) ? 6'h01 : half_q + 6'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_rxdv_sync; $changed(rxdv) |-> !rxclk; endproperty
    a_rxdv_sync: assert property (p_rxdv_sync) else $error("rxdv moved off rx clock fall");
    property p_rxer_sync; $changed(rxer) |-> !rxclk; endproperty
    a_rxer_sync: assert property (p_rxer_sync) else $error("rxer moved off rx clock fall");
    property p_rxd_sync; $changed(rxd) |-> !rxclk; endproperty
    a_rxd_sync: assert property (p_rxd_sync) else $error("rxd moved off rx clock fall");
    property p_frame_start; $rose(rxdv) |-> rxd == 4'h5 && !rxer; endproperty
    a_frame_start: assert property (p_frame_start) else $error("frame start wrong");
    property p_err_drop; $rose(rxer) && $past(rxdv) |-> !rxdv; endproperty
    a_err_drop: assert property (p_err_drop) else $error("rxdv kept after error");
    property p_false_carrier; $rose(rxer) && !$past(rxdv) |-> !rxdv && rxd == 4'he; endproperty
    a_false_carrier: assert property (p_false_carrier) else $error("false carrier code wrong");
    property p_err_hold; $rose(rxer) |-> rxer [*4]; endproperty
    a_err_hold: assert property (p_err_hold) else $error("rxer shorter than a period");
    property p_release; receive_tristate_request [*4] |-> !rx_out_en; endproperty
    a_release: assert property (p_release) else $error("rx pins still driven");
    property p_half; seen_q && (txclk ^ txclk_q) |-> half_q == 6'h02 || half_q == 6'h14; endproperty
    a_half: assert property (p_half) else $error("link clock half period wrong");
endmodule : mii_link_properties
`default_nettype wire

// ---- phy_mii_port_logic_tb.sv ----
// self-checking bench of the phy port and mac end joined over the link
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module phy_mii_port_logic_tb;
    import mii_port_pkg::*;
    logic    clk = 1'b0, rstn = 1'b0, speed_100 = 1'b1, code_test = 1'b0, rx_sym_valid = 1'b0;
    logic    rx_tristate = 1'b0, tx_valid = 1'b0, tx_err = 1'b0;
    logic    rx_sym_ready, tx_sym_valid, tx_active, tx_ready, rx_valid, rx_err, rx_frame;
    logic    [4:0] phy_addr = 5'h01;
    symbol_t alt_symbol = 5'h00, rx_sym = 5'h1f, tx_sym;
    nibble_t tx_nibble = 4'h0, rx_nibble;
    nibble_t rx_got[$], exp_rx[$];
    symbol_t tx_got[$], exp_tx[$];
    int      comparisons = 0, n_mismatch = 0, rx_errs = 0, full_seen = 0;
    logic    [31:0] rng = 32'h63;
    mii_link_if mii_link_if_i ();
    mii_phy_port mii_phy_port_i (.clk(clk), .rstn(rstn), .clk_en(1'b1), .speed_100(speed_100),
        .phy_addr(phy_addr), .invalid_code_test(code_test), .alt_symbol(alt_symbol),
        .rx_sym_valid(rx_sym_valid), .rx_sym(rx_sym), .rx_sym_ready(rx_sym_ready), .tx_sym_q(tx_sym),
        .tx_sym_valid_q(tx_sym_valid), .tx_active_q(tx_active), .link(mii_link_if_i));
    mii_mac_end mii_mac_end_i (.clk(clk), .rstn(rstn), .clk_en(1'b1), .rx_tristate(rx_tristate),
        .tx_valid(tx_valid), .tx_nibble(tx_nibble), .tx_err(tx_err), .tx_ready(tx_ready),
        .rx_valid_q(rx_valid), .rx_nibble_q(rx_nibble), .rx_err_q(rx_err), .rx_frame_q(rx_frame),
        .link(mii_link_if_i));
    mii_link_properties mii_link_properties_i (.clk(clk), .rstn(rstn), .rxclk(mii_link_if_i.rxclk),
        .rxdv(mii_link_if_i.rxdv), .rxer(mii_link_if_i.rxer), .rxd(mii_link_if_i.rxd),
        .rx_out_en(mii_link_if_i.rx_out_en), .txclk(mii_link_if_i.txclk),
        .receive_tristate_request(mii_link_if_i.receive_tristate_request));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #5 clk = ~clk;
    end
    // monitors; a refused push proves the two-entry buffer filled up
    always @(posedge clk) begin
        if (rx_valid && rx_frame) rx_got.push_back(rx_nibble);
        if (tx_sym_valid) tx_got.push_back(tx_sym);
        if (rx_err) rx_errs++;
        if (rx_sym_valid && !rx_sym_ready) full_seen++;
    end
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : rnd
    // expected five-bit code of a transmit nibble
    function automatic symbol_t enc(nibble_t n, logic e);
        symbol_t t[16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                           5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
        if (e && speed_100) return code_test ? alt_symbol : 5'h04;
        return t[n];
    endfunction : enc
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up
    // bounded wait for a level, then one edge so a handshake completes
    task automatic wait_lvl(ref logic s, input logic v);
        int n;
        for (n = 0; n < 1000 && s !== v; n++) @(posedge clk) #1;
        if (n == 1000) begin
            n_mismatch++;
            wrap_up();
        end
        @(posedge clk) #1;
    endtask : wait_lvl
    task automatic push(input symbol_t s);
        rx_sym_valid = 1'b1;
        rx_sym = s;
        wait_lvl(rx_sym_ready, 1'b1);
    endtask : push
    task automatic rx_run(input int len, input logic bad);
        nibble_t d;
        rx_got = {};
        exp_rx = {4'h5};
        push(5'h18);
        push(5'h11);
        for (int i = 0; i < len; i++) begin
            d = nibble_t'(rnd());
            exp_rx.push_back(d);
            push(enc(d, 1'b0));
        end
        if (bad) push(5'h00);
        else begin
            push(5'h0d);
            push(5'h07);
        end
        push(5'h1f);
        rx_sym_valid = 1'b0;
        wait_lvl(rx_frame, 1'b0);
        `CHK("rx count", 1'b1, rx_got.size() >= len + 1)
        for (int i = 0; i <= len; i++) `CHK("rx nibble", exp_rx[i], rx_got[i])
        $display("rx frame len %0d bad %0d errs %0d done", len, bad, rx_errs);
    endtask : rx_run
    task automatic tx_run(input int len);
        tx_got = {};
        exp_tx = {};
        for (int i = 0; i < len; i++) begin
            tx_valid = 1'b1;
            tx_nibble = nibble_t'(rnd());
            tx_err = (i == 1) || (rnd() % 3 == 0);
            exp_tx.push_back(enc(tx_nibble, tx_err));
            wait_lvl(tx_ready, 1'b1);
        end
        tx_valid = 1'b0;
        tx_err = 1'b0;
        wait_lvl(tx_active, 1'b0);
        `CHK("tx count", len, tx_got.size())
        for (int i = 0; i < len; i++) `CHK("tx symbol", exp_tx[i], tx_got[i])
        $display("tx frame len %0d speed %0d test %0d done", len, speed_100, code_test);
    endtask : tx_run
    // checks output release a few cycles after a request settles
    task automatic release_chk(input logic trq, input logic [4:0] addr, input logic en);
        rx_tristate = trq;
        phy_addr = addr;
        repeat (8) @(posedge clk) #1;
        `CHK("rx drive", en, mii_link_if_i.rx_out_en)
    endtask : release_chk
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        #1 rstn = 1'b1;
        rx_run(12, 1'b0);
        `CHK("buffer refused", 1'b1, full_seen > 0)
        rx_run(4, 1'b1);
        `CHK("frame error", 1'b1, rx_errs > 0)
        rx_errs = 0;
        push(5'h0e);
        push(5'h1f);
        rx_sym_valid = 1'b0;
        repeat (20) @(posedge clk) #1;
        `CHK("false carrier", 1'b1, rx_errs > 0)
        // a start delimiter without its second half is a false carrier too
        rx_errs = 0;
        push(5'h18);
        push(5'h0e);
        push(5'h1f);
        rx_sym_valid = 1'b0;
        repeat (20) @(posedge clk) #1;
        `CHK("lost delimiter", 1'b1, rx_errs > 0)
        tx_run(10);
        code_test = 1'b1;
        alt_symbol = symbol_t'(rnd());
        tx_run(8);
        release_chk(1'b1, 5'h03, 1'b0);
        release_chk(1'b0, 5'h00, 1'b0);
        release_chk(1'b0, 5'h1e, 1'b1);
        // slow mode under a fresh reset so the divider restarts cleanly
        rstn = 1'b0;
        speed_100 = 1'b0;
        repeat (12) @(posedge clk);
        #1 rstn = 1'b1;
        tx_run(4);
        rx_run(3, 1'b0);
        wrap_up();
    end
endmodule : phy_mii_port_logic_tb
`default_nettype wire
